// File: logic/cbl_loader.v
// configuration bitstream loader: serial, parallel and peripheral modes
// assumes mode pins, data, init and external clock are asynchronous pins;
// the frame logic deciding which bits overflow sits outside and drives
// forward_en; options learned from the bitstream arrive as level inputs
// Notes on behaviour
// - slave serial: host drives clock, device samples serial input at rise.
// - slave serial: forwarded bits change on falling edge, half period later.
// - mode 111 selects slave serial, the default with pins left open.
// - master serial: device drives clock, samples boot prom bit next rise.
// - master serial: forwarded bits delayed one and a half periods.
// - fast load option raises own clock rate eightfold.
// - low while loading stays high after configuration ends.
// - mode 000 selects master serial with device generated clock.
// - master parallel: capture byte just before address steps.
// - byte sent lsb first, bit zero out 1.5 periods after capture.
// - mode 100: address starts at zero, counts up.
// - mode 110: address starts at 3FFFF, counts down.
// - upper address lines undriven until bitstream asks for 22 lines.
// - low voltage variant always drives all 22 lines.
// - first byte loaded and clock starts when first read strobe ends.
// - peripheral: first byte on second rise after init, then every eighth.
// - accepting edge drives ready-busy high for one period.
// - ready-busy undriven before init goes high.
// - mode 011 selects synchronous peripheral mode.
// - peripheral: shifting starts half period after parallel load.
`timescale 1ns/1ns
`include "cbl_defines.vh"
module cbl_loader
#(
	parameter LOW_VOLT = 1'b0
)
(
	input wire ref_clk,
	input wire arst_n,
	input wire mode_sel_2,
	input wire mode_sel_1,
	input wire mode_sel_0,
	input wire init_pin,
	input wire config_done,
	input wire forward_en,
	input wire accelerated_load_clock,
	input wire address_width_option,
	input wire config_clock_in,
	output reg config_clock_out,
	output reg config_clock_oe,
	input wire serial_in,
	input wire [7:0] par_data,
	output reg serial_out,
	output reg [17:0] lower_address,
	output reg [3:0] upper_address_lines,
	output reg upper_address_oe,
	output reg address_oe,
	output reg read_strobe_n,
	output reg ready_busy,
	output reg ready_busy_oe,
	output reg low_while_loading,
	output reg bit_valid,
	output reg bit_data
);
// ----------------------------------------------------------------
// reset and input synchronisers
// ----------------------------------------------------------------
reg [1:0] rst_sync_q;
wire rst_n = rst_sync_q[1];
always @(posedge ref_clk or negedge arst_n)
begin
	if (!arst_n)
		rst_sync_q <= 2'h0;
	else
		rst_sync_q <= {rst_sync_q[0], 1'b1};
end

reg [13:0] meta_q;
reg [13:0] sync_q;
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		meta_q <= 14'h0000;
		sync_q <= 14'h0000;
	end
	else
	begin
		meta_q <= {par_data, serial_in, config_clock_in, init_pin,
			mode_sel_2, mode_sel_1, mode_sel_0};
		sync_q <= meta_q;
	end
end
wire [2:0] mode_pins = sync_q[2:0];
wire init_s = sync_q[3];
wire xclk_s = sync_q[4];
wire din_s = sync_q[5];
wire [7:0] pdata_s = sync_q[13:6];

// ----------------------------------------------------------------
// mode latch
// ----------------------------------------------------------------
localparam ST_IDLE = 2'h0;
localparam ST_LOAD = 2'h1;
localparam ST_END = 2'h2;
reg [1:0] state_q;
reg [2:0] mode_q;

function is_master;
	input [2:0] m;
	begin
		is_master = (m == `CBL_MODE_MSER) || (m == `CBL_MODE_MPUP) ||
			(m == `CBL_MODE_MPDN);
	end
endfunction
function is_par_master;
	input [2:0] m;
	begin
		is_par_master = (m == `CBL_MODE_MPUP) || (m == `CBL_MODE_MPDN);
	end
endfunction

always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		state_q <= ST_IDLE;
		mode_q <= `CBL_MODE_SSER;
	end
	else
	begin
		case (state_q)
			ST_IDLE:
				if (init_s)
				begin
					mode_q <= mode_pins;
					state_q <= ST_LOAD;
				end
			ST_LOAD:
				if (config_done)
					state_q <= ST_END;
			default:
				state_q <= ST_END;
		endcase
	end
end
wire loading = (state_q == ST_LOAD);
wire master = loading && is_master(mode_q);
wire par_master = loading && is_par_master(mode_q);

// ----------------------------------------------------------------
// own clock generator and edge detection
// ----------------------------------------------------------------
reg [7:0] div_q;
reg xclk_prev_q;
reg started_q;
wire [7:0] div_top = accelerated_load_clock ? `CBL_CLK_FAST_DIV :
	`CBL_CLK_SLOW_DIV;
wire own_tick = master && (div_q >= div_top);
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		div_q <= 8'h00;
		config_clock_out <= 1'b1;
		config_clock_oe <= 1'b0;
		xclk_prev_q <= 1'b0;
	end
	else
	begin
		xclk_prev_q <= xclk_s;
		config_clock_oe <= master;
		if (own_tick)
			div_q <= 8'h00;
		else if (master)
			div_q <= div_q + 8'h01;
		// clock held until first strobe ends
		if (own_tick && (started_q || !par_master))
			config_clock_out <= ~config_clock_out;
		else if (!master)
			config_clock_out <= 1'b1;
	end
end
wire own_rise = own_tick && !config_clock_out && (started_q || !par_master);
wire own_fall = own_tick && config_clock_out;
wire ext_rise = xclk_s && !xclk_prev_q;
wire ext_fall = !xclk_s && xclk_prev_q;
wire rise = loading && (is_master(mode_q) ? own_rise : ext_rise);
wire fall = loading && (is_master(mode_q) ? own_fall : ext_fall);

// ----------------------------------------------------------------
// data path: serial sample, byte capture, shifter
// ----------------------------------------------------------------
reg [7:0] shift_q;
reg [2:0] bit_cnt_q;
reg [3:0] edge_cnt_q;
reg pend_q;
reg pipe_q;
reg have_q;
wire serial_mode = (mode_q == `CBL_MODE_SSER) ||
	(mode_q == `CBL_MODE_MSER);
wire sper = loading && (mode_q == `CBL_MODE_SPER);
wire sper_take = sper && rise && (edge_cnt_q == `CBL_SPER_FIRST - 4'h1);
wire par_take = par_master && rise && (bit_cnt_q == `CBL_BIT_LAST);
wire first_strobe_end = par_master && !started_q && own_tick &&
	!read_strobe_n;
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		shift_q <= 8'h00;
		bit_cnt_q <= 3'h0;
		edge_cnt_q <= 4'h0;
		started_q <= 1'b0;
		pend_q <= 1'b0;
		pipe_q <= 1'b0;
		have_q <= 1'b0;
		bit_valid <= 1'b0;
		bit_data <= 1'b0;
		serial_out <= 1'b1;
		read_strobe_n <= 1'b1;
	end
	else
	begin
		bit_valid <= 1'b0;
		if (!loading)
		begin
			started_q <= 1'b0;
			edge_cnt_q <= 4'h0;
			bit_cnt_q <= 3'h0;
			have_q <= 1'b0;
			read_strobe_n <= 1'b1;
		end
		if (par_master && !started_q && own_tick)
			read_strobe_n <= ~read_strobe_n;
		// first byte at end of first strobe
		if (first_strobe_end)
		begin
			started_q <= 1'b1;
			shift_q <= pdata_s;
			bit_cnt_q <= 3'h0;
			have_q <= 1'b1;
		end
		else if (rise && serial_mode)
		begin
			pend_q <= din_s;
			bit_valid <= 1'b1;
			bit_data <= din_s;
			have_q <= 1'b1;
		end
		else if (par_take || sper_take)
		begin
			shift_q <= pdata_s;
			bit_cnt_q <= 3'h0;
			have_q <= 1'b1;
			// eight more rises to the next byte
			edge_cnt_q <= `CBL_SPER_FIRST - `CBL_BYTE_BITS;
		end
		else if (rise && have_q && !serial_mode)
		begin
			shift_q <= {1'b0, shift_q[7:1]};
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
		if (sper && rise && !sper_take)
			edge_cnt_q <= edge_cnt_q + 4'h1;
		if (fall && have_q)
		begin
			bit_valid <= !serial_mode;
			bit_data <= shift_q[0];
			pipe_q <= serial_mode ? pend_q : shift_q[0];
			if (forward_en)
			begin
				if (mode_q == `CBL_MODE_SSER)
					serial_out <= pend_q;
				else if (mode_q == `CBL_MODE_SPER)
					serial_out <= shift_q[0];
				else
					serial_out <= pipe_q;
			end
		end
	end
end

// ----------------------------------------------------------------
// byte memory address
// ----------------------------------------------------------------
reg [21:0] addr_q;
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		addr_q <= `CBL_ADDR_UP_START;
		lower_address <= 18'h00000;
		upper_address_lines <= 4'h0;
		upper_address_oe <= 1'b0;
		address_oe <= 1'b0;
	end
	else
	begin
		if (state_q == ST_IDLE)
			addr_q <= (mode_pins == `CBL_MODE_MPDN) ?
				`CBL_ADDR_DN_START : `CBL_ADDR_UP_START;
		else if ((par_take || first_strobe_end) &&
			(mode_q == `CBL_MODE_MPDN))
			addr_q <= addr_q - 22'h000001;
		else if (par_take || first_strobe_end)
			addr_q <= addr_q + 22'h000001;
		lower_address <= addr_q[`CBL_ADDR_LO_BITS-1:0];
		upper_address_lines <= addr_q[21:`CBL_ADDR_LO_BITS];
		address_oe <= par_master;
		upper_address_oe <= par_master &&
			(LOW_VOLT || address_width_option);
	end
end

// ----------------------------------------------------------------
// handshake and status pins
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		ready_busy <= 1'b1;
		ready_busy_oe <= 1'b0;
		low_while_loading <= 1'b1;
	end
	else
	begin
		ready_busy_oe <= sper;
		if (sper_take)
			ready_busy <= 1'b1;
		else if (sper && rise)
			ready_busy <= 1'b0;
		else if (!sper)
			ready_busy <= 1'b1;
		low_while_loading <= !loading;
	end
end
endmodule // cbl_loader

// File: logic/cbl_defines.vh
// constants for the configuration bitstream loader
// assumes inclusion by bare name from the design file
`ifndef CBL_DEFINES_VH
`define CBL_DEFINES_VH
`define CBL_MODE_MSER 3'h0
`define CBL_MODE_SPER 3'h3
`define CBL_MODE_MPUP 3'h4
`define CBL_MODE_MPDN 3'h6
`define CBL_MODE_SSER 3'h7
`define CBL_ADDR_UP_START 22'h000000
`define CBL_ADDR_DN_START 22'h03FFFF
`define CBL_ADDR_LO_BITS 18
`define CBL_CLK_SLOW_DIV 8'h1F
`define CBL_CLK_FAST_DIV 8'h03
`define CBL_SPER_FIRST 4'h2
`define CBL_BYTE_BITS 4'h8
`define CBL_BIT_LAST 3'h7
`endif

// File: dv/cbl_loader_props.sv
// checker on the loader ports
// assumes a bind from the bench top
`timescale 1ns/1ns
module cbl_loader_props
#(
	parameter LOW_VOLT = 1'b0
)
(
	input wire ref_clk,
	input wire arst_n,
	input wire init_pin,
	input wire config_done,
	input wire address_width_option,
	input wire [17:0] lower_address,
	input wire upper_address_oe,
	input wire address_oe,
	input wire ready_busy,
	input wire ready_busy_oe,
	input wire low_while_loading,
	input wire bit_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence ack_held;
		ready_busy[*4] ##[1:12] !ready_busy;
	endsequence
	chk_rb_undriven: assert property (!init_pin[*4] |-> !ready_busy_oe)
		else $error("ready_busy driven before init");
	chk_rb_after_init: assert property ($rose(ready_busy_oe) |-> $past(init_pin, 2))
		else $error("ready_busy enabled without init");
	chk_ack_width: assert property ($rose(ready_busy) && ready_busy_oe |-> ack_held)
		else $error("acknowledge width wrong");
	chk_ldc_done: assert property (config_done[*4] |-> low_while_loading)
		else $error("low_while_loading low after done");
	chk_upper_quiet: assert property (!LOW_VOLT && !address_width_option
		&& !$past(address_width_option) |-> !upper_address_oe)
		else $error("upper lines driven too early");
	chk_upper_drive: assert property (address_oe && address_width_option
		|-> ##[0:6] upper_address_oe)
		else $error("upper lines never driven");
	chk_addr_step: assert property (address_oe && $past(address_oe)
		&& lower_address != $past(lower_address)
		|-> lower_address == $past(lower_address) + 18'h1
		|| lower_address == $past(lower_address) - 18'h1)
		else $error("address step not one");
	chk_bit_spacing: assert property (bit_valid |=> !bit_valid[*3])
		else $error("bits too close");
endmodule // cbl_loader_props

// File: dv/cbl_far_side.sv
// far side: host clock and data, serial boot prom, byte memory
// assumes the bench raises host_run only after init is high
`timescale 1ns/1ns
module cbl_far_side
#(
	parameter PAT = 8'hC5
)
(
	input wire host_run,
	input wire arst_n,
	input wire config_clock_out,
	output reg config_clock_in,
	output wire serial_in,
	output wire [7:0] par_data
);
	integer n = 0;
	initial config_clock_in = 1'b0;
	// host clock parks low unless enabled
	always #160
		if (host_run || config_clock_in)
			config_clock_in = !config_clock_in;
	// host moves to the next bit after a falling edge
	// boot prom steps on each rising device clock
	always @(negedge config_clock_in or posedge config_clock_out
		or negedge arst_n)
		if (arst_n === 1'b1)
			n = n + 1;
		else
			n = 0;
	assign serial_in = PAT[n % 8];
	// memory and host present the same byte
	assign par_data = PAT;
endmodule // cbl_far_side

// File: dv/testbench.sv
// bench: every load mode through the far side model
// assumes checker and far side files are compiled first
`timescale 1ns/1ns
`include "cbl_defines.vh"
module testbench;
	localparam [7:0] PAT = 8'hC5;
	reg ref_clk, arst_n, init_pin, config_done, forward_en, host_run;
	reg accelerated_load_clock, address_width_option;
	reg mode_sel_2, mode_sel_1, mode_sel_0, par, so;
	wire config_clock_in, config_clock_out, config_clock_oe, serial_in;
	wire serial_out, upper_address_oe, address_oe, read_strobe_n;
	wire ready_busy, ready_busy_oe, low_while_loading, bit_valid, bit_data;
	wire [7:0] par_data;
	wire [17:0] lower_address;
	wire [3:0] upper_address_lines;
	integer miscompares, checks, k, t, ch, slow, lag;
	cbl_loader DUT(
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.mode_sel_2(mode_sel_2),
		.mode_sel_1(mode_sel_1),
		.mode_sel_0(mode_sel_0),
		.init_pin(init_pin),
		.config_done(config_done),
		.forward_en(forward_en),
		.accelerated_load_clock(accelerated_load_clock),
		.address_width_option(address_width_option),
		.config_clock_in(config_clock_in),
		.config_clock_out(config_clock_out),
		.config_clock_oe(config_clock_oe),
		.serial_in(serial_in),
		.par_data(par_data),
		.serial_out(serial_out),
		.lower_address(lower_address),
		.upper_address_lines(upper_address_lines),
		.upper_address_oe(upper_address_oe),
		.address_oe(address_oe),
		.read_strobe_n(read_strobe_n),
		.ready_busy(ready_busy),
		.ready_busy_oe(ready_busy_oe),
		.low_while_loading(low_while_loading),
		.bit_valid(bit_valid),
		.bit_data(bit_data)
	);
	cbl_far_side FAR(
		.host_run(host_run),
		.arst_n(arst_n),
		.config_clock_out(config_clock_out),
		.config_clock_in(config_clock_in),
		.serial_in(serial_in),
		.par_data(par_data)
	);
	task stop_test;
	begin
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task cmp(input string nm, input [21:0] e, input [21:0] g);
	begin
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task run(input [2:0] md, input f, input integer nb);
	begin
		@(negedge ref_clk);
		{arst_n, init_pin, host_run, config_done} = 4'h0;
		address_width_option = 1'b0;
		accelerated_load_clock = f;
		{mode_sel_2, mode_sel_1, mode_sel_0} = md;
		repeat (2) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (6) @(negedge ref_clk);
		init_pin = 1'b1;
		repeat (8) @(negedge ref_clk);
		par = md == `CBL_MODE_MPUP || md == `CBL_MODE_MPDN;
		lag = md == `CBL_MODE_SPER ? 0 : md == `CBL_MODE_MSER ? 2 : 1;
		cmp("clk_oe", md == `CBL_MODE_MSER || par, config_clock_oe);
		cmp("rb_oe", md == `CBL_MODE_SPER, ready_busy_oe);
		cmp("addr_oe", par, address_oe);
		if (par)
			cmp("addr", md[1] ? 18'h3FFFF : 18'h0, lower_address);
		cmp("ldc", 0, low_while_loading);
		host_run = !config_clock_oe;
		{mode_sel_2, mode_sel_1, mode_sel_0} = ~md;
		k = 0;
		ch = 0;
		so = serial_out;
		for (t = 0; t < 9000 && k < nb; t++)
		begin
			@(negedge ref_clk);
			if (serial_out !== so)
				ch++;
			so = serial_out;
			if (bit_valid === 1'b1)
			begin
				cmp("bit", PAT[k % 8], bit_data);
				if (k >= lag)
					cmp("dout", PAT[(k - lag) % 8], serial_out);
				k++;
			end
		end
		if (k < nb)
		begin
			$display("[ERR] bits exp %0d got %0d", nb, k);
			miscompares++;
			stop_test;
		end
		cmp("fwd", 1, ch > 3);
		cmp("mode_kept", md == `CBL_MODE_MSER || par, config_clock_oe);
		if (par)
		begin
			cmp("addr_end", md[1] ? 18'h3FFFF - nb / 8 : nb / 8, lower_address);
			cmp("up_addr", 0, upper_address_lines);
			cmp("strobe", 1, read_strobe_n);
			cmp("up_oe", 0, upper_address_oe);
			address_width_option = 1'b1;
			repeat (6) @(negedge ref_clk);
			cmp("up_oe", 1, upper_address_oe);
		end
		host_run = 1'b0;
		config_done = 1'b1;
		repeat (4) @(negedge ref_clk);
		cmp("ldc", 1, low_while_loading);
	end
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial
	begin
		{miscompares, checks} = 0;
		{arst_n, init_pin, host_run, config_done} = 4'h0;
		{accelerated_load_clock, address_width_option} = 2'h0;
		{mode_sel_2, mode_sel_1, mode_sel_0} = 3'h7;
		forward_en = 1'b1;
		repeat (2) @(negedge ref_clk);
		run(`CBL_MODE_SSER, 0, 24);
		run(`CBL_MODE_SPER, 0, 24);
		run(`CBL_MODE_MPUP, 0, 24);
		run(`CBL_MODE_MPDN, 0, 24);
		run(`CBL_MODE_MSER, 0, 16);
		slow = t;
		run(`CBL_MODE_MSER, 1, 16);
		cmp("fast", 1, t * 3 < slow);
		stop_test;
	end
endmodule // testbench
bind cbl_loader cbl_loader_props #(.LOW_VOLT(LOW_VOLT)) u_props(
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.init_pin(init_pin),
	.config_done(config_done),
	.address_width_option(address_width_option),
	.lower_address(lower_address),
	.upper_address_oe(upper_address_oe),
	.address_oe(address_oe),
	.ready_busy(ready_busy),
	.ready_busy_oe(ready_busy_oe),
	.low_while_loading(low_while_loading),
	.bit_valid(bit_valid)
);
